//--- core/spsp_pkg.sv
package spsp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SCLK_PERIOD_NS = 400;
    localparam int HALF_CYCLES    = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYCLES - 1);
    localparam int WORD_BITS      = 8;
    localparam logic [2:0] LAST_BIT  = 3'(WORD_BITS - 1);
    localparam logic [4:0] GAP_EXTRA = 5'h02;
    localparam logic [5:0] GAP_TRIM  = 6'h02;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TX0_OFS  = 8'h04;
    localparam logic [7:0] TX1_OFS  = 8'h08;
    localparam logic [7:0] RX0_OFS  = 8'h0C;
    localparam logic [7:0] RX1_OFS  = 8'h10;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int GO_BIT    = 0;
    localparam int WORDS_LSB = 8;
    localparam int POL_BIT   = 11;
    localparam int GAP_LSB   = 12;
    localparam int DONE_BIT  = 16;
    localparam int IE_BIT    = 17;

    // ------------------------------------------------------------------
    // Values after reset and encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] WORDS_RST    = 2'h0;
    localparam logic       POL_RST      = 1'b0;
    localparam logic [3:0] GAP_RST      = 4'h0;
    localparam logic       IE_RST       = 1'b0;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [1:0] WORDS_BURST  = 2'h1;

    typedef enum logic [2:0] {
        SPSP_IDLE  = 3'b001,
        SPSP_SHIFT = 3'b010,
        SPSP_GAP   = 3'b100
    } spsp_state_t;

endpackage

//--- core/spsp_ctrl.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps

module spsp_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             serialClockLine,
    output logic             serialDataOut,
    input  wire logic        serialDataIn,
    output logic             chipSelectN,
    output logic             irqOut
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    spsp_pkg::spsp_state_t stateReg;
    logic [3:0]  halfCntReg;
    logic [2:0]  bitCntReg;
    logic [5:0]  gapCntReg;
    logic        secondReg;
    logic [7:0]  shiftReg;
    logic [7:0]  rxShiftReg;
    logic        sclkReg;
    logic        mosiReg;
    logic        csNReg;
    logic        doneReg;
    logic        ieReg;
    logic        polReg;
    logic [3:0]  gapReg;
    logic [1:0]  wordsReg;
    logic [7:0]  tx0Reg;
    logic [7:0]  tx1Reg;
    logic [7:0]  rx0Reg;
    logic [7:0]  rx1Reg;
    logic [31:0] prdataReg;
    logic        preadyReg;
    logic        pslverrReg;
    logic        irqReg;
    logic        misoMetaReg;
    logic        misoSyncReg;
    logic [31:0] readData;
    logic [4:0]  gapSum;
    logic [5:0]  gapLoad;
    logic        leadDlyReg;
    function automatic logic addrHit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction
    wire setupDone = psel & penable & ~preadyReg;
    wire accessEnd = psel & penable & preadyReg;
    wire wrEn      = accessEnd & pwrite;
    wire ctrlWr    = wrEn & addrHit(paddr, spsp_pkg::CTRL_OFS);
    wire idle      = stateReg == spsp_pkg::SPSP_IDLE;
    wire start     = ctrlWr & pwdata[spsp_pkg::GO_BIT] & idle;
    wire tick      = halfCntReg == 4'h0;
    wire leadNow   = (stateReg == spsp_pkg::SPSP_SHIFT) & tick &
                     (sclkReg == polReg);
    wire trailNow  = (stateReg == spsp_pkg::SPSP_SHIFT) & tick &
                     (sclkReg != polReg);
    wire wordEnd   = trailNow & (bitCntReg == spsp_pkg::LAST_BIT);
    wire burstGo   = ~secondReg & (wordsReg == spsp_pkg::WORDS_BURST);
    wire setDone   = wordEnd & ~burstGo;
    wire mapped    = (paddr <= spsp_pkg::RX1_OFS) & (paddr[1:0] == 2'h0);
    assign gapSum  = {1'b0, gapReg} + spsp_pkg::GAP_EXTRA;
    assign gapLoad = {gapSum, 1'b0} - spsp_pkg::GAP_TRIM;
    assign prdata          = prdataReg;
    assign pready          = preadyReg;
    assign pslverr         = pslverrReg;
    assign serialClockLine = sclkReg;
    assign serialDataOut   = mosiReg;
    assign chipSelectN     = csNReg;
    assign irqOut          = irqReg;
    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // One wait state lets read data and the error flag come from flops.
    always_comb begin
        readData = 32'h0000_0000;
        if (addrHit(paddr, spsp_pkg::CTRL_OFS)) begin
            readData[spsp_pkg::GO_BIT]          = ~idle;
            readData[spsp_pkg::WORDS_LSB +: 2]  = wordsReg;
            readData[spsp_pkg::POL_BIT]         = polReg;
            readData[spsp_pkg::GAP_LSB +: 4]    = gapReg;
            readData[spsp_pkg::DONE_BIT]        = doneReg;
            readData[spsp_pkg::IE_BIT]          = ieReg;
        end else if (addrHit(paddr, spsp_pkg::TX0_OFS)) begin
            readData[7:0] = tx0Reg;
        end else if (addrHit(paddr, spsp_pkg::TX1_OFS)) begin
            readData[7:0] = tx1Reg;
        end else if (addrHit(paddr, spsp_pkg::RX0_OFS)) begin
            readData[7:0] = rx0Reg;
        end else if (addrHit(paddr, spsp_pkg::RX1_OFS)) begin
            readData[7:0] = rx1Reg;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            preadyReg  <= 1'b0;
            prdataReg  <= 32'h0000_0000;
            pslverrReg <= 1'b0;
        end else begin
            preadyReg <= setupDone;
            if (setupDone) begin
                prdataReg  <= pwrite ? 32'h0000_0000 : readData;
                pslverrReg <= ~mapped;
            end else if (accessEnd) begin
                pslverrReg <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    // Shape is frozen in a transfer so no word in flight sees it change.
    always_ff @(posedge clk) begin
        if (rst) begin
            wordsReg <= spsp_pkg::WORDS_RST;
            polReg   <= spsp_pkg::POL_RST;
            gapReg   <= spsp_pkg::GAP_RST;
            ieReg    <= spsp_pkg::IE_RST;
            tx0Reg   <= spsp_pkg::DATA_RST;
            tx1Reg   <= spsp_pkg::DATA_RST;
        end else begin
            if (ctrlWr) begin
                ieReg <= pwdata[spsp_pkg::IE_BIT];
            end
            if (ctrlWr & idle) begin
                wordsReg <= pwdata[spsp_pkg::WORDS_LSB +: 2];
                polReg   <= pwdata[spsp_pkg::POL_BIT];
                gapReg   <= pwdata[spsp_pkg::GAP_LSB +: 4];
            end
            if (wrEn & idle & addrHit(paddr, spsp_pkg::TX0_OFS)) begin
                tx0Reg <= pwdata[7:0];
            end
            if (wrEn & idle & addrHit(paddr, spsp_pkg::TX1_OFS)) begin
                tx1Reg <= pwdata[7:0];
            end
        end
    end
    // ------------------------------------------------------------------
    // Done flag and interrupt
    // ------------------------------------------------------------------
    // A completion in the cycle of a clearing write keeps the flag set.
    always_ff @(posedge clk) begin
        if (rst) begin
            doneReg <= 1'b0;
        end else if (setDone) begin
            doneReg <= 1'b1;
        end else if (start | (ctrlWr & pwdata[spsp_pkg::DONE_BIT])) begin
            doneReg <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        irqReg <= ~rst & doneReg & ieReg;
    end
    // ------------------------------------------------------------------
    // Serial input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            misoMetaReg <= 1'b0;
            misoSyncReg <= 1'b0;
        end else begin
            misoMetaReg <= serialDataIn;
            misoSyncReg <= misoMetaReg;
        end
    end
    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst | idle | start | tick) begin
            halfCntReg <= spsp_pkg::HALF_LAST;
        end else begin
            halfCntReg <= halfCntReg - 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg  <= spsp_pkg::SPSP_IDLE;
            sclkReg   <= spsp_pkg::POL_RST;
            csNReg    <= 1'b1;
            mosiReg   <= 1'b0;
            bitCntReg <= 3'h0;
            gapCntReg <= 6'h00;
            secondReg <= 1'b0;
            shiftReg  <= spsp_pkg::DATA_RST;
        end else begin
            case (stateReg)
                spsp_pkg::SPSP_IDLE: begin
                    sclkReg <= polReg;
                    csNReg  <= 1'b1;
                    if (start) begin
                        stateReg  <= spsp_pkg::SPSP_SHIFT;
                        csNReg    <= 1'b0;
                        shiftReg  <= tx0Reg;
                        mosiReg   <= tx0Reg[7];
                        bitCntReg <= 3'h0;
                        secondReg <= 1'b0;
                    end
                end
                spsp_pkg::SPSP_SHIFT: begin
                    if (leadNow) begin
                        sclkReg <= ~polReg;
                    end else if (trailNow) begin
                        sclkReg <= polReg;
                        if (wordEnd & burstGo) begin
                            stateReg  <= spsp_pkg::SPSP_GAP;
                            gapCntReg <= gapLoad;
                            secondReg <= 1'b1;
                            shiftReg  <= tx1Reg;
                            mosiReg   <= tx1Reg[7];
                            bitCntReg <= 3'h0;
                        end else if (wordEnd) begin
                            stateReg <= spsp_pkg::SPSP_IDLE;
                            csNReg   <= 1'b1;
                        end else begin
                            bitCntReg <= bitCntReg + 3'h1;
                            shiftReg  <= {shiftReg[6:0], 1'b0};
                            mosiReg   <= shiftReg[6];
                        end
                    end
                end
                spsp_pkg::SPSP_GAP: begin
                    if (tick & (gapCntReg == 6'h00)) begin
                        stateReg <= spsp_pkg::SPSP_SHIFT;
                    end else if (tick) begin
                        gapCntReg <= gapCntReg - 6'h01;
                    end
                end
                default: begin
                    stateReg <= spsp_pkg::SPSP_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            leadDlyReg <= 1'b0;
            rxShiftReg <= spsp_pkg::DATA_RST;
            rx0Reg     <= spsp_pkg::DATA_RST;
            rx1Reg     <= spsp_pkg::DATA_RST;
        end else begin
            leadDlyReg <= leadNow;
            if (leadDlyReg) begin
                rxShiftReg <= {rxShiftReg[6:0], misoSyncReg};
            end
            if (wordEnd & ~secondReg) begin
                rx0Reg <= rxShiftReg;
            end
            if (wordEnd & secondReg) begin
                rx1Reg <= rxShiftReg;
            end
        end
    end
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] sinceTrailReg;
    logic       afterGapReg;
    logic [7:0] gapExpect;
    localparam int HALF_CYCLES_L = spsp_pkg::HALF_CYCLES;
    assign gapExpect = 8'({3'h0, gapSum} * 8'(2 * HALF_CYCLES_L)) - 8'h01;
    always_ff @(posedge clk) begin
        if (rst | trailNow) begin
            sinceTrailReg <= 8'h00;
        end else if (sinceTrailReg != 8'hFF) begin
            sinceTrailReg <= sinceTrailReg + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (rst | leadNow) begin
            afterGapReg <= 1'b0;
        end else if (stateReg == spsp_pkg::SPSP_GAP) begin
            afterGapReg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence burstWordEnd;
        wordEnd && burstGo;
    endsequence
    done_busy_low_a: assert property (
        !idle && !setDone |=> !doneReg)
        else $error("done flag set during a transfer");
    done_on_end_a: assert property (
        setDone |=> doneReg && idle && csNReg)
        else $error("done flag not set at transfer end");
    w1c_keep_a: assert property (
        doneReg && ctrlWr && !start && !pwdata[spsp_pkg::DONE_BIT] |=> doneReg)
        else $error("done flag cleared by a zero write");
    gap_enter_a: assert property (
        burstWordEnd |=> stateReg == spsp_pkg::SPSP_GAP && !csNReg
                         && sclkReg == polReg)
        else $error("gap not entered after first burst word");
    gap_length_a: assert property (
        leadNow && afterGapReg |-> sinceTrailReg == gapExpect)
        else $error("suspend gap has wrong length");
    bit_spacing_a: assert property (
        leadNow && bitCntReg != 3'h0 |->
        sinceTrailReg == 8'(HALF_CYCLES_L - 1))
        else $error("trailing to leading spacing wrong");
    gap_reset_a: assert property ($past(rst) |-> gapReg == 4'h0)
        else $error("gap field not zero after reset");
    single_word_a: assert property (
        stateReg == spsp_pkg::SPSP_GAP |-> wordsReg == spsp_pkg::WORDS_BURST)
        else $error("gap used outside burst mode");
    idle_level_a: assert property (
        idle && $past(idle) |-> sclkReg == $past(polReg))
        else $error("serial clock not at idle level");
    irq_level_a: assert property (
        irqReg == $past(doneReg && ieReg))
        else $error("interrupt output mismatch");
endmodule

//--- testbench/spsp_slave.sv
`timescale 1ns/1ps

module spsp_slave #(
    parameter logic [7:0] REPLY0 = 8'hA5,
    parameter logic [7:0] REPLY1 = 8'h3C
) (
    input  wire logic       pol,
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       mosi,
    output logic            miso,
    output logic      [7:0] lastRx
);
    // ------------------------------------------------------------------
    // Peer device
    // ------------------------------------------------------------------
    // Deselected, the data line shows the inverse of its last bit, so a
    // master that samples outside a frame reads the wrong value.
    logic [7:0] rxShift = 8'h00;
    int         nBits   = 0;
    int         nWord   = 0;

    function automatic logic replyBit(input int w, input int b);
        logic [7:0] r;
        r = (w == 0) ? REPLY0 : REPLY1;
        return r[7 - b];
    endfunction

    initial begin
        miso   = 1'b0;
        lastRx = 8'h00;
    end

    always @(negedge csN) begin
        nBits = 0;
        nWord = 0;
        miso  = replyBit(0, 0);
    end

    always @(posedge csN) miso = ~miso;

    always @(sclk) begin
        if (csN === 1'b0 && sclk !== pol) begin
            rxShift = {rxShift[6:0], mosi};
            nBits   = nBits + 1;
            if (nBits == 8) begin
                lastRx = rxShift;
                nBits  = 0;
                nWord  = nWord + 1;
            end
        end else if (csN === 1'b0) begin
            miso = replyBit(nWord % 2, nBits);
        end
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [7:0] REPLY0 = 8'hA5;
    localparam logic [7:0] REPLY1 = 8'h3C;
    typedef struct packed {
        logic       pol;
        logic [1:0] words;
        logic [3:0] gap;
        logic       ie;
        int         expLeads;
        int         expGap;
    } spsp_row_t;
    spsp_row_t rows [5] = '{
        '{1'b0, 2'h1, 4'h0, 1'b1, 16, 8},
        '{1'b1, 2'h1, 4'h1, 1'b0, 16, 12},
        '{1'b0, 2'h1, 4'hF, 1'b1, 16, 68},
        '{1'b1, 2'h0, 4'hF, 1'b0, 8, 0},
        '{1'b0, 2'h3, 4'h5, 1'b1, 8, 0}
    };
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        serialClockLine;
    logic        serialDataOut;
    logic        serialDataIn;
    logic        chipSelectN;
    logic        irqOut;
    logic [7:0]  lastRx;
    logic        curPol  = 1'b0;
    logic        prevSclk = 1'b0;
    logic        prevCs  = 1'b1;
    logic [31:0] q;
    logic [31:0] cfg;
    logic        err;
    int mismatches = 0, n_checks = 0;
    int cyc = 0, leads = 0, trails = 0, tTrail8 = 0, gapMeas = 0;

    always #50 clk = ~clk;

    spsp_ctrl dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialClockLine(serialClockLine), .serialDataOut(serialDataOut),
        .serialDataIn(serialDataIn), .chipSelectN(chipSelectN),
        .irqOut(irqOut)
    );

    spsp_slave #(.REPLY0(REPLY0), .REPLY1(REPLY1)) peer (
        .pol(curPol), .sclk(serialClockLine), .csN(chipSelectN),
        .mosi(serialDataOut), .miso(serialDataIn), .lastRx(lastRx)
    );

    // ------------------------------------------------------------------
    // Link monitor
    // ------------------------------------------------------------------
    // Sampled on the falling clock edge so flop outputs have settled.
    always @(negedge clk) begin
        cyc++;
        if (chipSelectN === 1'b0 && prevCs === 1'b1) begin
            leads  = 0;
            trails = 0;
        end
        if (chipSelectN === 1'b0 && serialClockLine !== prevSclk) begin
            if (serialClockLine !== curPol) begin
                leads++;
                if (leads == 9) gapMeas = cyc - tTrail8;
            end else begin
                trails++;
                if (trails == 8) tTrail8 = cyc;
            end
        end
        prevSclk = serialClockLine;
        prevCs   = chipSelectN;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    function automatic logic [31:0] ctrlWord(input spsp_row_t r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[spsp_pkg::IE_BIT] = r.ie;
        w[spsp_pkg::GAP_LSB +: 4] = r.gap;
        w[spsp_pkg::POL_BIT] = r.pol;
        w[spsp_pkg::WORDS_LSB +: 2] = r.words;
        return w;
    endfunction

    task automatic runTransfer(input logic [31:0] c);
        int n;
        n = 0;
        wr(spsp_pkg::TX0_OFS, 32'h0000_00C3);
        wr(spsp_pkg::TX1_OFS, 32'h0000_005A);
        wr(spsp_pkg::CTRL_OFS, c);
        wr(spsp_pkg::CTRL_OFS, c | 32'h0000_0001);
        rd(spsp_pkg::CTRL_OFS);
        check(q[spsp_pkg::DONE_BIT], 1'b0);
        do begin
            rd(spsp_pkg::CTRL_OFS);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        check(q[0], 1'b0);
    endtask

    task automatic tally_and_finish;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(spsp_pkg::CTRL_OFS);
        check(q, 32'h0000_0000);
        check({chipSelectN, serialClockLine, irqOut}, 3'h4);
        foreach (rows[i]) begin
            curPol = rows[i].pol;
            cfg = ctrlWord(rows[i]);
            runTransfer(cfg);
            rd(spsp_pkg::CTRL_OFS);
            check(q[spsp_pkg::DONE_BIT], 1'b1);
            check(irqOut, rows[i].ie);
            check(leads, rows[i].expLeads);
            if (rows[i].expGap != 0) begin
                check(gapMeas, rows[i].expGap);
                rd(spsp_pkg::RX1_OFS);
                check({q[7:0], lastRx}, {REPLY1, 8'h5A});
            end else begin
                check(lastRx, 8'hC3);
            end
            check(serialClockLine, rows[i].pol);
            rd(spsp_pkg::RX0_OFS);
            check(q, {24'h000000, REPLY0});
            wr(spsp_pkg::CTRL_OFS, cfg | (32'h1 << spsp_pkg::DONE_BIT));
            rd(spsp_pkg::CTRL_OFS);
            check(q[spsp_pkg::DONE_BIT], 1'b0);
            check(irqOut, 1'b0);
        end
        curPol = 1'b0;
        runTransfer(32'h0000_0000);
        wr(spsp_pkg::CTRL_OFS, 32'h1 << spsp_pkg::IE_BIT);
        rd(spsp_pkg::CTRL_OFS);
        check(q[spsp_pkg::DONE_BIT], 1'b1);
        check(irqOut, 1'b1);
        wr(spsp_pkg::CTRL_OFS, 32'h0000_0000);
        rd(spsp_pkg::CTRL_OFS);
        check(irqOut, 1'b0);
        wr(spsp_pkg::CTRL_OFS, 32'h1 << spsp_pkg::DONE_BIT);
        rd(spsp_pkg::CTRL_OFS);
        check(q[spsp_pkg::DONE_BIT], 1'b0);
        rd(8'h20);
        check(err, 1'b1);
        check(q, 32'h0000_0000);
        wr(spsp_pkg::CTRL_OFS, 32'h1 << spsp_pkg::POL_BIT);
        rd(spsp_pkg::CTRL_OFS);
        check(serialClockLine, 1'b1);
        tally_and_finish;
    end
endmodule
